// >>> src/vocr_pkg.sv
package vocr_pkg;
  localparam int unsigned REG_W = 16;
  localparam int unsigned IDX_W = 5;
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL   = 5'h00;
  localparam logic [IDX_W-1:0] IDX_STAT   = 5'h01;
  localparam logic [IDX_W-1:0] IDX_IRQ    = 5'h02;
  localparam logic [IDX_W-1:0] IDX_FILL   = 5'h03;
  localparam logic [IDX_W-1:0] IDX_MODE   = 5'h04;
  localparam logic [IDX_W-1:0] IDX_M1CTL  = 5'h05;
  localparam logic [IDX_W-1:0] IDX_M1WID  = 5'h06;
  localparam logic [IDX_W-1:0] IDX_M1F0H  = 5'h07;
  localparam logic [IDX_W-1:0] IDX_M1F1H  = 5'h08;
  localparam logic [IDX_W-1:0] IDX_M1VAL  = 5'h1C;
  // control bits
  localparam int unsigned CTL_GO      = 0;
  localparam int unsigned CTL_UPD_EN  = 1;
  localparam int unsigned CTL_LCK_EN  = 2;
  localparam int unsigned CTL_SYNC_EN = 3;
  localparam int unsigned CTL_FLOCK   = 4;
  // status bits
  localparam int unsigned ST_ACTIVE = 0;
  localparam int unsigned ST_UNDER  = 2;
  localparam int unsigned ST_LOCKED = 3;
  // interrupt bits
  localparam int unsigned IRQ_UPD = 1;
  localparam int unsigned IRQ_LCK = 2;
  // mode control bits
  localparam int unsigned MC_INTERLACE = 0;
  localparam int unsigned MC_SEQ       = 1;
  localparam logic [REG_W-1:0] RST_VAL = 16'h0000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> src/vocr_w1c.sv
`timescale 1ns/1ps
// sticky flag: set wins over write-one clear
module vocr_w1c (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_q
);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flag_q <= 1'b0;
    else if (set_i)
      flag_q <= 1'b1;
    else if (clr_i)
      flag_q <= 1'b0;
  end
endmodule

// >>> src/vocr_regs.sv
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Behaviour
// - all registers sixteen bits wide
// - control bit 0 starts video output
// - control bit 1 enables update interrupt
// - control bit 2 enables locked interrupt
// - control bit 3 enables sync outputs
// - bit 4 with bit 3 enables frame locking
// - status bit 0 shows output active
// - status bit 1 unused
// - underflow sticky until written one
// - status bit 3 shows frame locked
// - interrupt bit 1 flags status update
// - interrupt bit 2 flags lock event
// - interrupt bits cleared by writing one
// - address 3 reads FIFO fill level
// - address 4 reads one-hot selected mode
// - mode bit 0 selects interlaced timing
// - mode bit 1 selects sequential planes
// - address 6 holds active width
// - address 7 holds field 0 height
// - address 8 holds field 1 height
// - mode registers are write-only
module vocr_regs #(
  parameter int unsigned FILL_W  = 16,
  parameter int unsigned MODES   = 1,
  parameter bit          SEQ_OK  = 1'b1
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      output_active,
  input  wire logic                      fifo_underflow,
  input  wire logic                      frame_locked,
  input  wire logic                      status_update,
  input  wire logic [FILL_W-1:0]         fifo_fill,
  input  wire logic [MODES-1:0]          mode_onehot,
  output logic                           go_q,
  output logic                           sync_out_en,
  output logic                           frame_lock_en,
  output logic                           mode1_interlaced_q,
  output logic                           mode1_sequential_q,
  output logic [vocr_pkg::REG_W-1:0]     mode1_width_q,
  output logic [vocr_pkg::REG_W-1:0]     mode1_f0_height_q,
  output logic [vocr_pkg::REG_W-1:0]     mode1_f1_height_q,
  output logic                           mode1_valid_q,
  output logic                           irq
);
  logic [vocr_pkg::REG_W-1:0]  ctrl_q;
  logic [vocr_pkg::IDX_W-1:0]  aw_idx_q;
  logic                        aw_have_q;
  logic [31:0]                 w_data_q;
  logic [3:0]                  w_strb_q;
  logic                        w_have_q;
  logic                        wr_fire;
  logic [vocr_pkg::IDX_W-1:0]  wr_idx;
  logic [vocr_pkg::REG_W-1:0]  wr_val;
  logic                        wr_lo;
  logic                        wr_hi;
  logic                        wr_ok;
  logic                        lock_q;
  logic                        lock_rise;
  logic                        under_q;
  logic                        upd_q;
  logic                        lck_q;
  logic                        clr_under;
  logic                        clr_upd;
  logic                        clr_lck;
  logic [vocr_pkg::REG_W-1:0]  rd_val;
  logic                        rd_ok;
  logic [vocr_pkg::REG_W-1:0]  fill_ext;
  logic [vocr_pkg::REG_W-1:0]  mode_ext;

  // write address and data taken independently
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      aw_idx_q  <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_q <= 1'b1;
      aw_idx_q  <= s_axi_awaddr[6:2];
    end
    else if (wr_fire)
      aw_have_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_have_q <= 1'b0;
  end

  assign wr_fire = aw_have_q && w_have_q;
  assign wr_idx  = aw_idx_q;
  assign wr_lo   = w_strb_q[0];
  assign wr_hi   = w_strb_q[1];

  // byte-lane merge onto a sixteen bit register
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] nw,
                                        input logic lo,
                                        input logic hi);
    merge = {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
  endfunction

  assign wr_val = w_data_q[vocr_pkg::REG_W-1:0];

  always_comb
  begin
    case (wr_idx)
      vocr_pkg::IDX_CTRL,
      vocr_pkg::IDX_STAT,
      vocr_pkg::IDX_IRQ,
      vocr_pkg::IDX_FILL,
      vocr_pkg::IDX_MODE,
      vocr_pkg::IDX_M1CTL,
      vocr_pkg::IDX_M1WID,
      vocr_pkg::IDX_M1F0H,
      vocr_pkg::IDX_M1F1H,
      vocr_pkg::IDX_M1VAL: wr_ok = 1'b1;
      default:             wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= vocr_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? vocr_pkg::RESP_OKAY : vocr_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_q <= vocr_pkg::RST_VAL;
    else if (wr_fire && wr_idx == vocr_pkg::IDX_CTRL)
      ctrl_q <= merge(ctrl_q, wr_val, wr_lo, wr_hi) & 16'h001F;
  end

  assign go_q = ctrl_q[vocr_pkg::CTL_GO];
  assign sync_out_en = ctrl_q[vocr_pkg::CTL_SYNC_EN];
  assign frame_lock_en = ctrl_q[vocr_pkg::CTL_SYNC_EN]
                       & ctrl_q[vocr_pkg::CTL_FLOCK];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode1_interlaced_q <= 1'b0;
      mode1_sequential_q <= 1'b0;
      mode1_width_q      <= vocr_pkg::RST_VAL;
      mode1_f0_height_q  <= vocr_pkg::RST_VAL;
      mode1_f1_height_q  <= vocr_pkg::RST_VAL;
      mode1_valid_q      <= 1'b0;
    end
    else if (wr_fire && wr_lo)
    begin
      case (wr_idx)
        vocr_pkg::IDX_M1CTL:
        begin
          mode1_interlaced_q <= wr_val[vocr_pkg::MC_INTERLACE];
          mode1_sequential_q <= SEQ_OK & wr_val[vocr_pkg::MC_SEQ];
        end
        vocr_pkg::IDX_M1WID: mode1_width_q <= merge(mode1_width_q,
                                               wr_val, wr_lo, wr_hi);
        vocr_pkg::IDX_M1F0H: mode1_f0_height_q <= merge(mode1_f0_height_q,
                                                   wr_val, wr_lo, wr_hi);
        vocr_pkg::IDX_M1F1H: mode1_f1_height_q <= merge(mode1_f1_height_q,
                                                   wr_val, wr_lo, wr_hi);
        vocr_pkg::IDX_M1VAL: mode1_valid_q <= wr_val[0];
        default: ;
      endcase
    end
    else if (wr_fire && wr_hi)
    begin
      case (wr_idx)
        vocr_pkg::IDX_M1WID: mode1_width_q <= merge(mode1_width_q,
                                               wr_val, 1'b0, 1'b1);
        vocr_pkg::IDX_M1F0H: mode1_f0_height_q <= merge(mode1_f0_height_q,
                                                   wr_val, 1'b0, 1'b1);
        vocr_pkg::IDX_M1F1H: mode1_f1_height_q <= merge(mode1_f1_height_q,
                                                   wr_val, 1'b0, 1'b1);
        default: ;
      endcase
    end
  end

  // lock edge detect
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lock_q <= 1'b0;
    else
      lock_q <= frame_locked;
  end
  assign lock_rise = frame_locked & !lock_q;

  assign clr_under = wr_fire && wr_lo && wr_idx == vocr_pkg::IDX_STAT
                   && wr_val[vocr_pkg::ST_UNDER];
  assign clr_upd   = wr_fire && wr_lo && wr_idx == vocr_pkg::IDX_IRQ
                   && wr_val[vocr_pkg::IRQ_UPD];
  assign clr_lck   = wr_fire && wr_lo && wr_idx == vocr_pkg::IDX_IRQ
                   && wr_val[vocr_pkg::IRQ_LCK];

  vocr_w1c u_under (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_i   (fifo_underflow),
    .clr_i   (clr_under),
    .flag_q  (under_q)
  );

  vocr_w1c u_upd (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_i   (status_update & ctrl_q[vocr_pkg::CTL_UPD_EN]),
    .clr_i   (clr_upd),
    .flag_q  (upd_q)
  );

  vocr_w1c u_lck (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_i   (lock_rise & ctrl_q[vocr_pkg::CTL_LCK_EN]),
    .clr_i   (clr_lck),
    .flag_q  (lck_q)
  );

  assign irq = (upd_q & ctrl_q[vocr_pkg::CTL_UPD_EN])
             | (lck_q & ctrl_q[vocr_pkg::CTL_LCK_EN]);

  assign fill_ext = vocr_pkg::REG_W'(fifo_fill);
  assign mode_ext = vocr_pkg::REG_W'(mode_onehot);

  // read mux, write-only registers read zero
  always_comb
  begin
    rd_val = 16'h0000;
    rd_ok  = 1'b1;
    case (s_axi_araddr[6:2])
      vocr_pkg::IDX_CTRL: rd_val = ctrl_q;
      vocr_pkg::IDX_STAT:
      begin
        rd_val[vocr_pkg::ST_ACTIVE] = output_active;
        rd_val[vocr_pkg::ST_UNDER]  = under_q;
        rd_val[vocr_pkg::ST_LOCKED] = frame_locked;
      end
      vocr_pkg::IDX_IRQ:
      begin
        rd_val[vocr_pkg::IRQ_UPD] = upd_q;
        rd_val[vocr_pkg::IRQ_LCK] = lck_q;
      end
      vocr_pkg::IDX_FILL: rd_val = fill_ext;
      vocr_pkg::IDX_MODE: rd_val = mode_ext;
      vocr_pkg::IDX_M1CTL,
      vocr_pkg::IDX_M1WID,
      vocr_pkg::IDX_M1F0H,
      vocr_pkg::IDX_M1F1H,
      vocr_pkg::IDX_M1VAL: rd_val = 16'h0000;
      default: rd_ok = 1'b0;
    endcase
    if (s_axi_araddr[7])
      rd_ok = 1'b0;
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= vocr_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rd_val};
      s_axi_rresp  <= rd_ok ? vocr_pkg::RESP_OKAY : vocr_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule

// >>> tb/vocr_regs_asserts.sv
`timescale 1ns/1ps
module vocr_regs_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        go_q,
  input wire logic        sync_out_en,
  input wire logic        frame_lock_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  lock_needs_sync_a: assert property (frame_lock_en |-> sync_out_en)
    else $error("frame lock on without sync outputs");
  go_write_a: assert property ($changed(go_q) |-> $rose(s_axi_bvalid))
    else $error("go bit moved outside a write");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  w_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
endmodule
bind vocr_regs vocr_regs_asserts vocr_regs_asserts_i (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .go_q, .sync_out_en, .frame_lock_en);

// >>> tb/vocr_regs_tb_top.sv
`timescale 1ns/1ps
module vocr_regs_tb_top;
  logic        aclk, aresetn;
  logic [3:0]  wstrb;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        act, under, locked, upd;
  logic [15:0] fill, m_w, m_h0, m_h1;
  logic [0:0]  onehot;
  logic        go, sync_en, lock_en, m_il, m_seq, m_val, irq;
  int          err_count, n_checks;
  vocr_regs vocr_regs_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .output_active(act),
    .fifo_underflow(under), .frame_locked(locked), .status_update(upd),
    .fifo_fill(fill), .mode_onehot(onehot), .go_q(go),
    .sync_out_en(sync_en), .frame_lock_en(lock_en),
    .mode1_interlaced_q(m_il), .mode1_sequential_q(m_seq),
    .mode1_width_q(m_w), .mode1_f0_height_q(m_h0),
    .mode1_f1_height_q(m_h1), .mode1_valid_q(m_val), .irq(irq));
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic guard(inout int i);
    i++;
    if (i > 50)
    begin
      err_count++;
      $display("CHECK FAILED handshake expected answer seen none");
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [4:0] x, input logic [15:0] d,
                    input logic [1:0] er = 2'h0,
                    input logic [3:0] st = 4'hF);
    logic [1:0] r;
    logic       aw_t, w_t, b_t;
    int         i;
    r = 2'h0;
    b_t = 1'b0;
    i = 0;
    @(posedge aclk);
    awaddr  <= {1'b0, x, 2'h0};
    wdata   <= {16'h0000, d};
    wstrb   <= st;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(negedge aclk);
      guard(i);
      aw_t = awvalid && (awready === 1'b1);
      w_t  = wvalid && (wready === 1'b1);
      b_t  = (bvalid === 1'b1);
      r    = bresp;
      @(posedge aclk);
      if (aw_t)
        awvalid <= 1'b0;
      if (w_t)
        wvalid <= 1'b0;
    end
    while (!b_t);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rd(input logic [4:0] x, input logic [31:0] e);
    logic [31:0] r;
    logic [1:0]  rr;
    logic        ar_t, r_t;
    int          i;
    r = 32'h0;
    rr = 2'h0;
    r_t = 1'b0;
    i = 0;
    @(posedge aclk);
    araddr  <= {1'b0, x, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(negedge aclk);
      guard(i);
      ar_t = arvalid && (arready === 1'b1);
      r_t  = (rvalid === 1'b1);
      r    = rdata;
      rr   = rresp;
      @(posedge aclk);
      if (ar_t)
        arvalid <= 1'b0;
    end
    while (!r_t);
    rready <= 1'b0;
    chk("rdata", e, r);
    chk("rresp", 32'h0, {30'h0, rr});
  endtask
  task automatic s_ctrl;
    wr(5'h00, 16'hFFFF);
    rd(5'h00, 32'h001F);
    chk("sync_en", 32'h1, {31'h0, sync_en});
    chk("go", 32'h1, {31'h0, go});
    chk("lock_en", 32'h1, {31'h0, lock_en});
    wr(5'h00, 16'h0011);
    chk("sync_en", 32'h0, {31'h0, sync_en});
    chk("lock_en", 32'h0, {31'h0, lock_en});
  endtask
  task automatic s_stat;
    act <= 1'b1;
    locked <= 1'b1;
    under <= 1'b1;
    @(posedge aclk);
    under <= 1'b0;
    rd(5'h01, 32'h000D);
    wr(5'h01, 16'h0004);
    rd(5'h01, 32'h0009);
    act <= 1'b0;
    locked <= 1'b0;
  endtask
  task automatic s_irq;
    wr(5'h00, 16'h0006);
    chk("go", 32'h0, {31'h0, go});
    upd <= 1'b1;
    @(posedge aclk);
    upd <= 1'b0;
    @(negedge aclk);
    chk("irq", 32'h1, {31'h0, irq});
    rd(5'h02, 32'h0002);
    wr(5'h02, 16'h0002);
    rd(5'h02, 32'h0000);
    chk("irq", 32'h0, {31'h0, irq});
    locked <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(5'h02, 32'h0004);
    chk("irq", 32'h1, {31'h0, irq});
    wr(5'h00, 16'h0002);
    chk("irq", 32'h0, {31'h0, irq});
    wr(5'h02, 16'h0004);
    rd(5'h02, 32'h0000);
  endtask
  task automatic s_mode;
    fill <= 16'hA5C3;
    onehot <= 1'b1;
    rd(5'h03, 32'hA5C3);
    rd(5'h04, 32'h0001);
    wr(5'h05, 16'h0003);
    wr(5'h06, 16'h0780);
    wr(5'h07, 16'h021C);
    wr(5'h08, 16'h0438);
    wr(5'h1C, 16'h0001);
    chk("interlace", 32'h1, {31'h0, m_il});
    chk("sequential", 32'h1, {31'h0, m_seq});
    chk("width", 32'h0780, {16'h0, m_w});
    chk("f0_height", 32'h021C, {16'h0, m_h0});
    chk("f1_height", 32'h0438, {16'h0, m_h1});
    chk("valid", 32'h1, {31'h0, m_val});
    rd(5'h06, 32'h0000);
    wr(5'h09, 16'h1234, 2'h2);
    chk("width", 32'h0780, {16'h0, m_w});
    wr(5'h06, 16'hFFFF, 2'h0, 4'h2);
    chk("width", 32'hFF80, {16'h0, m_w});
  endtask
  task automatic s_reset_vals;
    rd(5'h00, 32'h0000);
    rd(5'h02, 32'h0000);
    chk("irq", 32'h0, {31'h0, irq});
    chk("width", 32'h0, {16'h0, m_w});
    chk("valid", 32'h0, {31'h0, m_val});
  endtask
  task automatic s_midrst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    s_reset_vals();
  endtask
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {act, under, locked, upd, awaddr, araddr, wdata} = '0;
    fill = 16'h0000;
    wstrb = 4'hF;
    onehot = 1'b0;
    err_count = 0;
    n_checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    s_reset_vals();
    s_ctrl();
    s_stat();
    s_irq();
    s_mode();
    s_midrst();
    tally_and_finish();
  end
endmodule
